// ==== design/tte_core.sv ====
// decode/execute core for test, undefined, zero-extend and hint instructions
// Summary of operation
// - Halfword bits 15:6 = 0100001000 is the AND test; operands in 5:3 and 2:0.
// - AND test sets N, Z, C, keeps V, writes no register.
// - Zero shift on second operand, so carry equals current carry flag.
// - Halfword bits 15:8 = 11011110 is permanently undefined with 8-bit immediate.
// - Wide form 111101111111/imm4 then 1010/imm12 is permanently undefined.
// - Undefined encodings raise undefined exception, no register or memory update.
// - Immediate of undefined encodings is ignored entirely.
// - Bits 15:6 = 1011001011 zero-extends source byte into destination.
// - Bits 15:6 = 1011001010 zero-extends source halfword into destination.
// - Wait-for-event clears a registered event and continues, else waits.
// - Wait-for-interrupt suspends until wake-up, raising no exception.
// - With mask bit set, only strictly higher priority exceptions end the wait; here the mask bit is not used and strictly higher priority always ends it.
// - Yield hints a swap-out; here it only signals and has no effect.
//
// Our own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module tte_core
	import tte_pkg::*;
#(
	parameter int unsigned PRIO_W = TTE_PRIO_W
)(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic instr_valid,
	input wire logic [15:0] instr_hw0,
	input wire logic [15:0] instr_hw1,
	output logic instr_ready,
	output logic [TTE_RIDX_W-1:0] rf_ra_idx,
	output logic [TTE_RIDX_W-1:0] rf_rb_idx,
	input wire logic [31:0] rf_rdata_a,
	input wire logic [31:0] rf_rdata_b,
	output logic rf_we,
	output logic [TTE_RIDX_W-1:0] rf_waddr,
	output logic [31:0] rf_wdata,
	output tte_flags_s flags,
	output logic undef_exc,
	output logic yield_hint,
	output logic sleeping,
	output logic priority_mask_bit,
	input wire logic event_in,
	input wire logic irq_pend,
	input wire logic [PRIO_W-1:0] irq_prio,
	input wire logic [PRIO_W-1:0] exec_prio,
	output logic irq
);
	tte_dec_s dec;
	tte_state_e state, next_state;
	tte_flags_s next_flags;
	logic take, wake_irq, event_reg, next_event_reg;
	logic [31:0] tst_res;
	logic next_rf_we, next_undef_exc, next_yield_hint, next_other;
	logic [TTE_RIDX_W-1:0] next_rf_waddr;
	logic [31:0] next_rf_wdata;
	logic ap_valid, ap_write, next_ap_valid, next_ap_write;
	logic [4:0] ap_addr, next_ap_addr;
	logic [31:0] next_hrdata;
	logic next_pm, bus_wr;
	logic [TTE_ST_W-1:0] status, next_status, mask, next_mask, ev_bits;

	tte_decode u_decode (
		.hw0(instr_hw0),
		.hw1(instr_hw1),
		.dec(dec)
	);

	assign instr_ready = ce && state == ST_RUN;
	assign take = instr_valid && instr_ready;
	assign rf_ra_idx = dec.ra;
	assign rf_rb_idx = dec.rb;
	// first operand and shifted second, shift amount zero
	assign tst_res = rf_rdata_a & rf_rdata_b;
	// only a strictly higher priority than the running level ends a wait
	assign wake_irq = irq_pend && (irq_prio < exec_prio);
	assign sleeping = state != ST_RUN;
	assign hreadyout = ce;
	assign hresp = 1'b0;
	assign bus_wr = ce && ap_valid && ap_write;
	assign irq = |(status & mask);

	// execution and flags
	always_comb begin
		next_flags = flags;
		next_rf_we = 1'b0;
		next_rf_waddr = rf_waddr;
		next_rf_wdata = rf_wdata;
		next_undef_exc = 1'b0;
		next_yield_hint = 1'b0;
		next_other = 1'b0;
		if (bus_wr && ap_addr == TTE_OFF_FLAGS) begin
			next_flags = hwdata[TTE_FLAGS_LSB +: 4];
		end
		if (take) begin
			case (dec.op)
				OP_AND_TEST: begin
					next_flags.n = tst_res[31];
					next_flags.z = (tst_res == 32'h0);
					next_flags.c = flags.c;
					// overflow kept even against a same-cycle bus write
					next_flags.v = flags.v;
				end
				OP_UNDEF: begin
					next_undef_exc = 1'b1;
				end
				OP_ZX_BYTE: begin
					next_rf_we = 1'b1;
					next_rf_waddr = dec.rd;
					next_rf_wdata = {24'h0, rf_rdata_b[7:0]};
				end
				OP_ZX_HALF: begin
					next_rf_we = 1'b1;
					next_rf_waddr = dec.rd;
					next_rf_wdata = {16'h0, rf_rdata_b[15:0]};
				end
				OP_YIELD: begin
					// no multithreading here, so the hint is only reported
					next_yield_hint = 1'b1;
				end
				OP_WFE, OP_WFI, OP_NONE: begin
					next_other = 1'b0;
				end
				default: begin
					next_other = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags <= '0;
			rf_we <= 1'b0;
			rf_waddr <= '0;
			rf_wdata <= 32'h0;
			undef_exc <= 1'b0;
			yield_hint <= 1'b0;
		end else if (ce) begin
			flags <= next_flags;
			rf_we <= next_rf_we;
			rf_waddr <= next_rf_waddr;
			rf_wdata <= next_rf_wdata;
			undef_exc <= next_undef_exc;
			yield_hint <= next_yield_hint;
		end
	end

	// wait states and event register
	always_comb begin
		next_state = state;
		next_event_reg = event_reg;
		case (state)
			ST_RUN: begin
				if (take && dec.op == OP_WFE) begin
					if (event_reg) begin
						next_event_reg = 1'b0;
					end else begin
						next_state = ST_WAIT_EVT;
					end
				end else if (take && dec.op == OP_WFI) begin
					next_state = ST_WAIT_IRQ;
				end
			end
			ST_WAIT_EVT: begin
				if (event_reg) begin
					next_event_reg = 1'b0;
					next_state = ST_RUN;
				end else if (wake_irq) begin
					next_state = ST_RUN;
				end
			end
			ST_WAIT_IRQ: begin
				if (wake_irq) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
		// an arriving event beats the clear
		if (event_in) begin
			next_event_reg = 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_RUN;
			event_reg <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			event_reg <= next_event_reg;
		end
	end

	// bus slave, interrupt status and mask
	always_comb begin
		next_ap_valid = ap_valid;
		next_ap_write = ap_write;
		next_ap_addr = ap_addr;
		next_hrdata = hrdata;
		next_pm = priority_mask_bit;
		next_mask = mask;
		ev_bits = '0;
		ev_bits[TTE_ST_UNDEF] = next_undef_exc;
		ev_bits[TTE_ST_WAKE] = sleeping && next_state == ST_RUN;
		ev_bits[TTE_ST_YIELD] = next_yield_hint;
		ev_bits[TTE_ST_OTHER] = next_other;
		next_status = status;
		if (bus_wr) begin
			case (ap_addr)
				TTE_OFF_CTRL: next_pm = hwdata[TTE_CTRL_PM_BIT];
				TTE_OFF_STATUS: next_status = status & ~hwdata[TTE_ST_W-1:0];
				TTE_OFF_MASK: next_mask = hwdata[TTE_ST_W-1:0];
				default: next_mask = mask;
			endcase
		end
		// set wins over a same-cycle write-one clear
		next_status = next_status | ev_bits;
		if (hready) begin
			next_ap_valid = hsel && htrans[1];
			next_ap_write = hwrite;
			next_ap_addr = {haddr[4:2], 2'b00};
			next_hrdata = 32'h0;
			case ({haddr[4:2], 2'b00})
				TTE_OFF_CTRL: next_hrdata[TTE_CTRL_PM_BIT] = priority_mask_bit;
				TTE_OFF_FLAGS: next_hrdata[TTE_FLAGS_LSB +: 4] = flags;
				TTE_OFF_STATUS: next_hrdata[TTE_ST_W-1:0] = status;
				TTE_OFF_MASK: next_hrdata[TTE_ST_W-1:0] = mask;
				TTE_OFF_STATE: next_hrdata[2:0] = {event_reg, state};
				default: next_hrdata = 32'h0;
			endcase
			if (|haddr[31:5]) begin
				next_hrdata = 32'h0;
				next_ap_valid = 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_valid <= 1'b0;
			ap_write <= 1'b0;
			ap_addr <= '0;
			hrdata <= 32'h0;
			priority_mask_bit <= 1'b0;
			status <= TTE_STATUS_RST;
			mask <= TTE_MASK_RST;
		end else if (ce) begin
			ap_valid <= next_ap_valid;
			ap_write <= next_ap_write;
			ap_addr <= next_ap_addr;
			hrdata <= next_hrdata;
			priority_mask_bit <= next_pm;
			status <= next_status;
			mask <= next_mask;
		end
	end

	property p_and_test_nz;
		@(posedge hclk) disable iff (!hresetn)
		take && dec.op == OP_AND_TEST |=>
			flags.z == ($past(tst_res) == 32'h0) && flags.n == $past(tst_res[31]);
	endproperty
	a_and_test_nz: assert property (p_and_test_nz) else $error("and test flags wrong");

	property p_and_test_cv;
		@(posedge hclk) disable iff (!hresetn)
		take && dec.op == OP_AND_TEST |=> $stable(flags.c) && $stable(flags.v) && !rf_we;
	endproperty
	a_and_test_cv: assert property (p_and_test_cv) else $error("and test changed c, v or reg");

	property p_undef;
		@(posedge hclk) disable iff (!hresetn)
		take && dec.op == OP_UNDEF |=> undef_exc && !rf_we && status[TTE_ST_UNDEF];
	endproperty
	a_undef: assert property (p_undef) else $error("undefined op did not trap");

	property p_zx_byte;
		@(posedge hclk) disable iff (!hresetn)
		take && dec.op == OP_ZX_BYTE |=>
			rf_we && rf_wdata == ($past(rf_rdata_b) & 32'h000000ff) && rf_waddr == $past(dec.rd);
	endproperty
	a_zx_byte: assert property (p_zx_byte) else $error("byte extend wrong");

	property p_zx_half;
		@(posedge hclk) disable iff (!hresetn)
		take && dec.op == OP_ZX_HALF |=> rf_we && rf_wdata == ($past(rf_rdata_b) & 32'h0000ffff);
	endproperty
	a_zx_half: assert property (p_zx_half) else $error("halfword extend wrong");

	property p_wfe_event;
		@(posedge hclk) disable iff (!hresetn)
		take && dec.op == OP_WFE && event_reg && !event_in |=> state == ST_RUN && !event_reg;
	endproperty
	a_wfe_event: assert property (p_wfe_event) else $error("wait for event did not consume");

	property p_wfi_enter;
		@(posedge hclk) disable iff (!hresetn)
		take && dec.op == OP_WFI |=> state == ST_WAIT_IRQ && !undef_exc && !instr_ready;
	endproperty
	a_wfi_enter: assert property (p_wfi_enter) else $error("wait for irq not entered");

	property p_wfi_exit;
		@(posedge hclk) disable iff (!hresetn)
		ce && state == ST_WAIT_IRQ |=> (state == ST_RUN) == $past(wake_irq);
	endproperty
	a_wfi_exit: assert property (p_wfi_exit) else $error("irq wait exit wrong");

	property p_yield;
		@(posedge hclk) disable iff (!hresetn)
		take && dec.op == OP_YIELD |=> yield_hint && !rf_we && state == ST_RUN;
	endproperty
	a_yield: assert property (p_yield) else $error("yield had an effect");
endmodule
`default_nettype wire

// ==== design/tte_pkg.sv ====
// shared constants and types for the compact instruction decode/execute block
package tte_pkg;
	localparam int unsigned TTE_DATA_W = 32;
	localparam int unsigned TTE_RIDX_W = 3;
	localparam int unsigned TTE_PRIO_W = 2;
	localparam logic [9:0] TTE_PAT_AND_TEST = 10'h108;
	localparam logic [9:0] TTE_PAT_ZX_BYTE = 10'h2cb;
	localparam logic [9:0] TTE_PAT_ZX_HALF = 10'h2ca;
	localparam logic [7:0] TTE_PAT_UNDEF16 = 8'hde;
	localparam logic [11:0] TTE_PAT_UNDEF32_HI = 12'hf7f;
	localparam logic [3:0] TTE_PAT_UNDEF32_LO = 4'ha;
	localparam logic [15:0] TTE_PAT_WFE = 16'hbf20;
	localparam logic [15:0] TTE_PAT_WFI = 16'hbf30;
	localparam logic [15:0] TTE_PAT_YIELD = 16'hbf10;
	localparam logic [4:0] TTE_WIDE_MIN = 5'h1d;
	localparam logic [4:0] TTE_OFF_CTRL = 5'h00;
	localparam logic [4:0] TTE_OFF_FLAGS = 5'h04;
	localparam logic [4:0] TTE_OFF_STATUS = 5'h08;
	localparam logic [4:0] TTE_OFF_MASK = 5'h0c;
	localparam logic [4:0] TTE_OFF_STATE = 5'h10;
	localparam int unsigned TTE_CTRL_PM_BIT = 0;
	localparam int unsigned TTE_FLAGS_LSB = 28;
	localparam int unsigned TTE_ST_UNDEF = 0;
	localparam int unsigned TTE_ST_WAKE = 1;
	localparam int unsigned TTE_ST_YIELD = 2;
	localparam int unsigned TTE_ST_OTHER = 3;
	localparam int unsigned TTE_ST_W = 4;
	localparam logic [TTE_ST_W-1:0] TTE_STATUS_RST = 4'h0;
	localparam logic [TTE_ST_W-1:0] TTE_MASK_RST = 4'h0;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0,
		OP_AND_TEST = 4'h1,
		OP_UNDEF = 4'h2,
		OP_ZX_BYTE = 4'h3,
		OP_ZX_HALF = 4'h4,
		OP_WFE = 4'h5,
		OP_WFI = 4'h6,
		OP_YIELD = 4'h7,
		OP_OTHER = 4'h8
	} tte_op_e;
	typedef enum logic [1:0] {
		ST_RUN = 2'h0,
		ST_WAIT_EVT = 2'h1,
		ST_WAIT_IRQ = 2'h2
	} tte_state_e;
	typedef struct packed {
		tte_op_e op;
		logic [TTE_RIDX_W-1:0] ra;
		logic [TTE_RIDX_W-1:0] rb;
		logic [TTE_RIDX_W-1:0] rd;
	} tte_dec_s;
	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} tte_flags_s;
endpackage

// ==== design/tte_decode.sv ====
// combinational decoder for the supported halfword encodings
`timescale 1ns/100ps
`default_nettype none
module tte_decode
	import tte_pkg::*;
(
	input wire logic [15:0] hw0,
	input wire logic [15:0] hw1,
	output tte_dec_s dec
);
	always_comb begin
		dec.op = OP_OTHER;
		// low register indices only, taken as unsigned field values
		dec.ra = hw0[2:0];
		dec.rb = hw0[5:3];
		dec.rd = hw0[2:0];
		if (hw0[15:6] == TTE_PAT_AND_TEST) begin
			dec.op = OP_AND_TEST;
		end else if (hw0[15:8] == TTE_PAT_UNDEF16) begin
			dec.op = OP_UNDEF;
		end else if (hw0[15:4] == TTE_PAT_UNDEF32_HI && hw1[15:12] == TTE_PAT_UNDEF32_LO) begin
			dec.op = OP_UNDEF;
		end else if (hw0[15:6] == TTE_PAT_ZX_BYTE) begin
			dec.op = OP_ZX_BYTE;
		end else if (hw0[15:6] == TTE_PAT_ZX_HALF) begin
			dec.op = OP_ZX_HALF;
		end else if (hw0 == TTE_PAT_WFE) begin
			dec.op = OP_WFE;
		end else if (hw0 == TTE_PAT_WFI) begin
			dec.op = OP_WFI;
		end else if (hw0 == TTE_PAT_YIELD) begin
			dec.op = OP_YIELD;
		end
		// immediates of the undefined forms are never looked at
	end
endmodule
`default_nettype wire

// ==== verification/tte_rf_model.sv ====
// register file model that answers the core's operand reads and takes its writes
`timescale 1ns/100ps
`default_nettype none
module tte_rf_model
	import tte_pkg::*;
(
	input wire logic hclk,
	input wire logic [TTE_RIDX_W-1:0] ra_idx,
	input wire logic [TTE_RIDX_W-1:0] rb_idx,
	output logic [31:0] rdata_a,
	output logic [31:0] rdata_b,
	input wire logic we,
	input wire logic [TTE_RIDX_W-1:0] waddr,
	input wire logic [31:0] wdata
);
	logic [31:0] regs [8];
	// same-cycle answers, as a flop-array read port would give
	assign rdata_a = regs[ra_idx];
	assign rdata_b = regs[rb_idx];
	always @(posedge hclk) begin
		if (we === 1'b1) begin
			regs[waddr] <= wdata;
		end
	end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the decode/execute core
`timescale 1ns/100ps
`default_nettype none
module tb
	import tte_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, instr_valid, event_in, irq_pend, ce;
	logic [31:0] haddr, hwdata, hrdata, rda, rdb, rf_wdata, rd;
	logic [1:0] htrans, irq_prio, exec_prio;
	logic [15:0] hw0, hw1;
	logic [2:0] ra, rb, rf_waddr;
	logic hreadyout, hresp, instr_ready, rf_we, undef_exc, yield_hint, sleeping, pm, irq;
	tte_flags_s flags;
	int num_errors, num_checks, n;
	tte_core uut (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .instr_valid(instr_valid),
		.instr_hw0(hw0), .instr_hw1(hw1), .instr_ready(instr_ready), .rf_ra_idx(ra),
		.rf_rb_idx(rb), .rf_rdata_a(rda), .rf_rdata_b(rdb), .rf_we(rf_we),
		.rf_waddr(rf_waddr), .rf_wdata(rf_wdata), .flags(flags), .undef_exc(undef_exc),
		.yield_hint(yield_hint), .sleeping(sleeping), .priority_mask_bit(pm),
		.event_in(event_in), .irq_pend(irq_pend), .irq_prio(irq_prio),
		.exec_prio(exec_prio), .irq(irq));
	tte_rf_model u_rf (.hclk(hclk), .ra_idx(ra), .rb_idx(rb), .rdata_a(rda), .rdata_b(rdb),
		.we(rf_we), .waddr(rf_waddr), .wdata(rf_wdata));
	initial begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [4:0] off, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= (off == 5'h1f) ? 32'h100 : {27'h0, off};
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
		#1;
	endtask
	// waits out wait states so a request is never dropped while refused
	task automatic exe(input logic [15:0] a, input logic [15:0] b);
		@(posedge hclk);
		instr_valid <= 1'b1;
		hw0 <= a;
		hw1 <= b;
		#1;
		while (instr_ready !== 1'b1) begin
			@(posedge hclk);
			#1;
		end
		@(posedge hclk);
		instr_valid <= 1'b0;
		#1;
	endtask
	task automatic wake();
		n = 0;
		while (sleeping !== 1'b0 && n < 20) begin
			@(posedge hclk);
			#1;
			n++;
		end
	endtask
	initial begin
		#40000;
		num_errors++;
		end_sim();
	end
	initial begin
		{hsel, hwrite, instr_valid, event_in, irq_pend} = '0;
		{haddr, hwdata, htrans, irq_prio, hw0, hw1} = '0;
		exec_prio = 2'd1;
		ce = 1'b1;
		u_rf.regs = '{32'h12345678, 32'h0f0f0f0f, 32'hf0f0f0f0, 32'h800000f0,
			32'hf000000f, 32'h0000a5c3, 32'hdeadbeef, 32'hffffffff};
		hresetn = 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		#1;
		chk({28'h0, flags}, 32'h0);
		bus(1'b1, 5'h1f, 32'hffffffff);
		bus(1'b0, 5'h1f, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, TTE_OFF_CTRL, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, TTE_OFF_MASK, 32'h0);
		chk(rd, {28'h0, TTE_MASK_RST});
		exe({TTE_PAT_ZX_BYTE, 3'd7, 3'd0}, 16'h0);
		chk({28'h0, rf_we, rf_waddr}, {28'h0, 1'b1, 3'd0});
		chk(rf_wdata, 32'h000000ff);
		exe({TTE_PAT_ZX_HALF, 3'd6, 3'd5}, 16'h0);
		chk({28'h0, rf_we, rf_waddr}, {28'h0, 1'b1, 3'd5});
		chk(rf_wdata, 32'h0000beef);
		bus(1'b1, TTE_OFF_FLAGS, 32'h30000000);
		chk({28'h0, flags}, 32'h3);
		exe({TTE_PAT_AND_TEST, 3'd4, 3'd3}, 16'h0);
		chk({rf_we, flags}, 5'b01011);
		bus(1'b1, TTE_OFF_FLAGS, 32'h0);
		exe({TTE_PAT_AND_TEST, 3'd2, 3'd1}, 16'h0);
		chk({rf_we, flags}, 5'b00100);
		for (int i = 0; i < 4; i++) begin
			if (i < 2) exe({TTE_PAT_UNDEF16, i[0] ? 8'hff : 8'h00}, 16'h0);
			else exe({TTE_PAT_UNDEF32_HI, i[0] ? 4'hf : 4'h0},
				{TTE_PAT_UNDEF32_LO, i[0] ? 12'hfff : 12'h000});
			chk({undef_exc, rf_we, flags}, 6'b100100);
		end
		bus(1'b0, TTE_OFF_STATUS, 32'h0);
		chk(rd, 32'h1);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, TTE_OFF_MASK, 32'h1);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, TTE_OFF_STATUS, 32'h1);
		chk({31'h0, irq}, 32'h0);
		exe(TTE_PAT_YIELD, 16'h0);
		chk({yield_hint, rf_we, undef_exc}, 3'b100);
		exe(TTE_PAT_WFE, 16'h0);
		chk({31'h0, sleeping}, 32'h1);
		@(posedge hclk);
		event_in <= 1'b1;
		@(posedge hclk);
		event_in <= 1'b0;
		wake();
		chk({31'h0, sleeping}, 32'h0);
		bus(1'b0, TTE_OFF_STATE, 32'h0);
		chk(rd, 32'h0);
		@(posedge hclk);
		event_in <= 1'b1;
		@(posedge hclk);
		event_in <= 1'b0;
		bus(1'b0, TTE_OFF_STATE, 32'h0);
		chk(rd, 32'h4);
		exe(TTE_PAT_WFE, 16'h0);
		chk({31'h0, sleeping}, 32'h0);
		bus(1'b0, TTE_OFF_STATUS, 32'h0);
		chk(rd, 32'h6);
		// an event arriving while frozen must not be registered
		@(posedge hclk);
		ce <= 1'b0;
		event_in <= 1'b1;
		@(posedge hclk);
		event_in <= 1'b0;
		#1;
		chk({29'h0, hresp, hreadyout, instr_ready}, 32'h0);
		@(posedge hclk);
		ce <= 1'b1;
		bus(1'b0, TTE_OFF_STATE, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, TTE_OFF_STATUS, 32'hf);
		// unsupported encoding: reported only, no trap and no write
		exe(16'h0000, 16'h0);
		chk({30'h0, undef_exc, rf_we}, 32'h0);
		bus(1'b1, TTE_OFF_CTRL, 32'h1);
		chk({31'h0, pm}, 32'h1);
		@(posedge hclk);
		irq_pend <= 1'b1;
		irq_prio <= 2'd1;
		exe(TTE_PAT_WFI, 16'h0);
		chk({undef_exc, sleeping}, 2'b01);
		repeat (6) @(posedge hclk);
		#1;
		chk({31'h0, sleeping}, 32'h1);
		@(posedge hclk);
		irq_prio <= 2'd0;
		wake();
		chk({31'h0, sleeping}, 32'h0);
		bus(1'b0, TTE_OFF_STATUS, 32'h0);
		chk(rd, 32'ha);
		end_sim();
	end
endmodule
`default_nettype wire
